// [rtl/mid_consts.vh]
`ifndef MID_CONSTS_VH
`define MID_CONSTS_VH
`define MID_IW            14
`define MID_CLK_PER_CYC   4
`define MID_F_LSB         0
`define MID_F_MSB         6
`define MID_D_BIT         7
`define MID_B_LSB         7
`define MID_B_MSB         9
`define MID_K8_MSB        7
`define MID_K11_MSB       10
`define MID_K7_MSB        6
`define MID_K5_MSB        4
`define MID_K9_MSB        8
`define MID_K6_MSB        5
`define MID_PTR_OFF_BIT   6
`define MID_PTR_INC_BIT   2
`define MID_IND0_ADDR     7'h00
`define MID_IND1_ADDR     7'h01
`define MID_NOP_WORD      14'h0000
`endif

// [rtl/mid_phase_gen.v]
`timescale 1ns/10ps
`include "mid_consts.vh"
// Divides the oscillator clock into the four phases of one instruction cycle.
module mid_phase_gen (
  input  wire       sys_clk,   // oscillator clock
  input  wire       resetn,    // async reset, active low
  output reg        cyc_end    // one-cycle pulse on the last phase
);
  reg  [1:0] phase_ff;
  wire [1:0] nxt_phase;
  assign nxt_phase = phase_ff + 2'h1;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
      cyc_end  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      cyc_end  <= (phase_ff == 2'h2);
    end
  end
endmodule

// [rtl/mid_class_rom.v]
`timescale 1ns/10ps
`include "mid_consts.vh"
// Combinational opcode classifier; every bit listed as don't-care is ignored.
module mid_class_rom (
  input  wire [13:0] iw,         // instruction word
  output reg  [3:0]  fmt,        // format code
  output reg         two_cyc,    // always two cycles
  output reg         cond_br,    // two cycles only if it branches
  output reg         uses_file   // names a file register
);
  always @* begin
    fmt       = 4'h0;
    two_cyc   = 1'b0;
    cond_br   = 1'b0;
    uses_file = 1'b0;
    casez (iw)
      14'b00_????_????_????: begin
        if (iw[13:8] == 6'h00) begin
          if (iw[7] == 1'b1) begin
            fmt       = 4'h1;
            uses_file = 1'b1;
          end else if (iw[7:5] == 3'b001) begin
            fmt = 4'h5;
          end else if (iw[7:3] == 5'b00010) begin
            fmt = 4'h8;
          end else begin
            fmt = 4'h0;
            if (iw[7:0] == 8'h08 || iw[7:0] == 8'h09 || iw[7:0] == 8'h0A ||
                iw[7:0] == 8'h0B || iw[7:0] == 8'h0E)
              two_cyc = 1'b1;
          end
        end else begin
          fmt       = 4'h1;
          uses_file = 1'b1;
          if (iw[11:8] == 4'hB || iw[11:8] == 4'hF)
            cond_br = 1'b1;
        end
      end
      14'b01_????_????_????: begin
        fmt       = 4'h2;
        uses_file = 1'b1;
        if (iw[11] == 1'b1)
          cond_br = 1'b1;
      end
      14'b10_????_????_????: begin
        fmt     = 4'h4;
        two_cyc = 1'b1;
      end
      14'b11_0100_????_????: begin
        fmt     = 4'h3;
        two_cyc = 1'b1;
      end
      14'b11_0001_0???_????: fmt = 4'h7;
      14'b11_0001_1???_????: fmt = 4'h6;
      14'b11_001?_????_????: begin
        fmt     = 4'h9;
        two_cyc = 1'b1;
      end
      default: fmt = 4'h3;
    endcase
  end
endmodule

// [rtl/mid_decoder.v]
`timescale 1ns/10ps
`include "mid_consts.vh"
// Overview of operation
// - Each instruction is one 14-bit word with opcode and all operands.
// - Instructions complete in one instruction cycle unless a longer class applies.
// - Subroutine jump and accumulator subroutine jump take two cycles.
// - Subroutine, literal and interrupt exits take two cycles.
// - Jumps and taken skips take two cycles when they branch.
// - Indirect access while the pointer addresses program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - A file operand is read, modified, then written, except bit tests, which write nothing; read always happens.
// - File address operand spans 0x00 to 0x7F in the selected bank.
// - Destination bit zero writes accumulator; one writes the file register.
// - Don't-care encoding bits never change the decode.
// - Pointer number selects pointer zero or one.
// - Byte format: address in bits 6..0, destination bit 7, opcode above.
// - Bit format: 3-bit bit number directly above the 7-bit address.
// - Literal format: 8-bit immediate in bits 7..0.
// - Subroutine and absolute jump: 11-bit target, opcode in bits 13..11.
// - Page latch load: 7-bit immediate in bits 6..0.
// - Bank select load: 5-bit immediate in bits 4..0.
// - Relative jump: 9-bit offset in bits 8..0, opcode in 13..9.
// - Pointer increment: pointer bit 2, 2-bit mode in bits 1..0.
module mid_decoder (
  input  wire        sys_clk,       // oscillator clock, 10 MHz
  input  wire        resetn,        // async reset, active low
  input  wire [13:0] prog_word,     // word fetched from program memory
  input  wire        branch_taken,  // core reports the condition met this cycle
  input  wire        ptr_in_prog,   // selected pointer addresses program memory
  output reg         fetch_ff,      // pulse: take next program word
  output reg         exec_ff,       // pulse: decoded fields below are valid
  output reg  [3:0]  fmt_ff,        // format code of the executing word
  output reg  [5:0]  opcode_ff,     // opcode bits 13..8
  output reg  [6:0]  file_addr_ff,  // file register address
  output reg         dest_file_ff,  // 1: result to file, 0: accumulator
  output reg  [2:0]  bit_sel_ff,    // bit number in file register
  output reg  [10:0] literal_ff,    // immediate, right aligned
  output reg         ptr_sel_ff,    // pointer zero or one
  output reg  [1:0]  ptr_mode_ff,   // pre/post increment/decrement mode
  output reg         rd_file_ff,    // pulse: read the file register
  output reg         wr_file_ff,    // pulse: write the file register
  output reg         wr_acc_ff,     // pulse: write the accumulator
  output reg         idle_ff        // high during an idle extra cycle
);
  localparam ST_RUN  = 3'b001;
  localparam ST_IDLE = 3'b010;
  localparam ST_IND  = 3'b100;

  wire       cyc_end;
  wire [3:0] fmt;
  wire       two_cyc;
  wire       cond_br;
  wire       uses_file;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [13:0] iw_ff;
  reg  [1:0]  sub_ff;
  reg         pend_ff;
  wire        is_ind;

  mid_phase_gen u_phase (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .cyc_end (cyc_end)
  );

  mid_class_rom u_class (
    .iw        (iw_ff),
    .fmt       (fmt),
    .two_cyc   (two_cyc),
    .cond_br   (cond_br),
    .uses_file (uses_file)
  );

  // Indirect registers sit at the low two addresses of every bank.
  assign is_ind = uses_file && (iw_ff[6:1] == 6'h00);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (is_ind && ptr_in_prog)
          nxt_state = ST_IND;
        else if (two_cyc || (cond_br && branch_taken))
          nxt_state = ST_IDLE;
        else
          nxt_state = ST_RUN;
      end
      ST_IND: begin
        if (two_cyc || (cond_br && branch_taken))
          nxt_state = ST_IDLE;
        else
          nxt_state = ST_RUN;
      end
      ST_IDLE: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff     <= ST_RUN;
      iw_ff        <= `MID_NOP_WORD;
      sub_ff       <= 2'h0;
      pend_ff      <= 1'b0;
      fetch_ff     <= 1'b0;
      exec_ff      <= 1'b0;
      fmt_ff       <= 4'h0;
      opcode_ff    <= 6'h00;
      file_addr_ff <= 7'h00;
      dest_file_ff <= 1'b0;
      bit_sel_ff   <= 3'h0;
      literal_ff   <= 11'h000;
      ptr_sel_ff   <= 1'b0;
      ptr_mode_ff  <= 2'h0;
      rd_file_ff   <= 1'b0;
      wr_file_ff   <= 1'b0;
      wr_acc_ff    <= 1'b0;
      idle_ff      <= 1'b0;
    end else begin
      fetch_ff   <= 1'b0;
      exec_ff    <= 1'b0;
      rd_file_ff <= 1'b0;
      wr_file_ff <= 1'b0;
      wr_acc_ff  <= 1'b0;
      if (cyc_end) begin
        state_ff <= nxt_state;
        idle_ff  <= (nxt_state != ST_RUN);
        if (nxt_state == ST_RUN) begin
          // Nothing is taken during an idle slot, so a redirect may replace the offered word.
          iw_ff    <= prog_word;
          fetch_ff <= 1'b1;
          pend_ff  <= 1'b1;
        end
        if (nxt_state == ST_IDLE && state_ff != ST_IDLE)
          iw_ff <= `MID_NOP_WORD;
      end
      // Field split happens on the phase after the word is latched.
      if (pend_ff) begin
        pend_ff      <= 1'b0;
        exec_ff      <= 1'b1;
        fmt_ff       <= fmt;
        opcode_ff    <= iw_ff[13:8];
        file_addr_ff <= iw_ff[`MID_F_MSB:`MID_F_LSB];
        dest_file_ff <= iw_ff[`MID_D_BIT];
        bit_sel_ff   <= iw_ff[`MID_B_MSB:`MID_B_LSB];
        ptr_sel_ff   <= 1'b0;
        ptr_mode_ff  <= 2'h0;
        case (fmt)
          4'h3: literal_ff <= {3'h0, iw_ff[`MID_K8_MSB:0]};
          4'h4: literal_ff <= iw_ff[`MID_K11_MSB:0];
          4'h6: literal_ff <= {4'h0, iw_ff[`MID_K7_MSB:0]};
          4'h5: literal_ff <= {6'h00, iw_ff[`MID_K5_MSB:0]};
          4'h9: literal_ff <= {2'h0, iw_ff[`MID_K9_MSB:0]};
          4'h7: begin
            literal_ff <= {5'h00, iw_ff[`MID_K6_MSB:0]};
            ptr_sel_ff <= iw_ff[`MID_PTR_OFF_BIT];
          end
          4'h8: begin
            literal_ff  <= 11'h000;
            ptr_sel_ff  <= iw_ff[`MID_PTR_INC_BIT];
            ptr_mode_ff <= iw_ff[1:0];
          end
          default: literal_ff <= 11'h000;
        endcase
        if (uses_file) begin
          rd_file_ff <= 1'b1;
          sub_ff     <= 2'h1;
        end
      end else if (sub_ff == 2'h1) begin
        sub_ff <= 2'h2;
      end else if (sub_ff == 2'h2) begin
        sub_ff <= 2'h0;
        // Skip/test forms with no store write neither target.
        if (fmt_ff == 4'h1 && !(opcode_ff[5:1] == 5'h00 && !dest_file_ff &&
            opcode_ff[0] == 1'b0)) begin
          wr_file_ff <= dest_file_ff;
          wr_acc_ff  <= !dest_file_ff;
        end else if (fmt_ff == 4'h2 && opcode_ff[5:4] == 2'b01 && !opcode_ff[3]) begin
          wr_file_ff <= 1'b1;
        end
      end
    end
  end
endmodule

// [testbench/mid_chk_asserts.sv]
`timescale 1ns/10ps
module mid_chk (
  input wire       sys_clk,      // clock
  input wire       resetn,       // reset, active low
  input wire       fetch_ff,     // fetch pulse
  input wire       exec_ff,      // execute pulse
  input wire [5:0] opcode_ff,    // opcode
  input wire [6:0] file_addr_ff, // file address
  input wire       dest_file_ff, // destination
  input wire [2:0] bit_sel_ff,   // bit number
  input wire       rd_file_ff,   // file read
  input wire       wr_file_ff,   // file write
  input wire       idle_ff,      // idle cycle
  input wire       wr_acc_ff     // accumulator write
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet;
    !fetch_ff [*3];
  endsequence
  chk_exec_follows: assert property (fetch_ff |=> exec_ff)
    else $error("exec pulse missing after fetch");
  chk_exec_cause: assert property (exec_ff |-> $past(fetch_ff))
    else $error("exec pulse without fetch");
  chk_cycle_min: assert property (fetch_ff |=> s_quiet)
    else $error("fetch sooner than four clocks");
  chk_cycle_max: assert property (fetch_ff |-> ##[4:12] fetch_ff)
    else $error("fetch later than three cycles");
  chk_idle_hold: assert property (idle_ff |-> !fetch_ff)
    else $error("fetch during idle cycle");
  chk_read_first: assert property (wr_file_ff |-> $past(rd_file_ff, 2))
    else $error("file write without prior read");
  chk_read_exec: assert property (rd_file_ff |-> exec_ff)
    else $error("file read outside execute");
  chk_field_hold: assert property (!exec_ff |-> $stable(opcode_ff) &&
    $stable(file_addr_ff) && $stable(bit_sel_ff))
    else $error("fields changed between executes");
  chk_bit_overlap: assert property (exec_ff |-> bit_sel_ff[0] == dest_file_ff)
    else $error("bit field not above address");
  chk_write_single: assert property (!(wr_file_ff && wr_acc_ff))
    else $error("file and accumulator written together");
  chk_acc_read: assert property (wr_acc_ff |-> $past(rd_file_ff, 2))
    else $error("accumulator write without prior read");
  chk_idle_exec: assert property (idle_ff |-> !exec_ff)
    else $error("execute pulse during idle cycle");
endmodule

// [testbench/mid_prog_mem.sv]
`timescale 1ns/10ps
// The next word appears only after a fetch, so a decoder that samples early sees stale data.
module mid_prog_mem (
  input  wire        sys_clk,     // clock
  input  wire        resetn,      // reset, active low
  input  wire        fetch_ff,    // word taken
  output reg  [13:0] prog_word,   // word to decoder
  output reg         ptr_in_prog  // pointer flag of executing word
);
  reg [13:0] mem [0:127];
  reg        ind [0:127];
  integer    pc;
  initial begin
    prog_word = 14'h0000;
    ptr_in_prog = 1'b0;
  end
  always @(negedge sys_clk) begin
    if (!resetn) begin
      pc = 0;
      prog_word <= mem[0];
      ptr_in_prog <= 1'b0;
    end else if (fetch_ff) begin
      prog_word <= mem[pc+1];
      ptr_in_prog <= ind[pc];
      pc = pc + 1;
    end
  end
endmodule

// [testbench/mid_decoder_tb_top.sv]
`timescale 1ns/10ps
module mid_decoder_tb_top;
  reg         sys_clk, resetn, branch_taken, p, bt;
  reg  [13:0] w;
  reg  [12:0] r;
  wire [13:0] prog_word;
  wire [3:0]  fmt_ff;
  wire [5:0]  opcode_ff;
  wire [6:0]  file_addr_ff;
  wire [2:0]  bit_sel_ff;
  wire [10:0] literal_ff;
  wire [1:0]  ptr_mode_ff;
  wire        ptr_in_prog, fetch_ff, exec_ff, dest_file_ff, ptr_sel_ff;
  wire        rd_file_ff, wr_file_ff, wr_acc_ff, idle_ff;
  integer     seed, n_mismatch, checked, cycles, last, k, i, t;
  mid_decoder DUT (.sys_clk(sys_clk), .resetn(resetn), .prog_word(prog_word),
    .branch_taken(branch_taken), .ptr_in_prog(ptr_in_prog), .fetch_ff(fetch_ff),
    .exec_ff(exec_ff), .fmt_ff(fmt_ff), .opcode_ff(opcode_ff), .file_addr_ff(file_addr_ff),
    .dest_file_ff(dest_file_ff), .bit_sel_ff(bit_sel_ff), .literal_ff(literal_ff),
    .ptr_sel_ff(ptr_sel_ff), .ptr_mode_ff(ptr_mode_ff), .rd_file_ff(rd_file_ff),
    .wr_file_ff(wr_file_ff), .wr_acc_ff(wr_acc_ff), .idle_ff(idle_ff));
  mid_prog_mem u_mem (.sys_clk(sys_clk), .resetn(resetn), .fetch_ff(fetch_ff),
    .prog_word(prog_word), .ptr_in_prog(ptr_in_prog));
  function file_of(input [13:0] v);
    file_of = v[13:12] == 2'b01 || (v[13:12] == 2'b00 && (v[11:8] != 4'h0 || v[7]));
  endfunction
  function cond_of(input [13:0] v);
    cond_of = v[13:12] == 2'b01 ? v[11] : file_of(v) && (v[11:8] == 4'hB || v[11:8] == 4'hF);
  endfunction
  function integer cyc_of(input [13:0] v, input f, input b);
    cyc_of = 1 + ((v >= 14'h0008 && v <= 14'h000B) || v == 14'h000E || v[13:12] == 2'b10 ||
      v[13:8] == 6'h34 || v[13:9] == 5'h19 || (cond_of(v) && b)) +
      (file_of(v) && v[6:1] == 6'h00 && f);
  endfunction
  function [3:0] fmt_of(input [13:0] v);
    fmt_of = file_of(v) ? (v[12] ? 4'h2 : 4'h1) : v[13:12] == 2'b10 ? 4'h4 :
      v[13:9] == 5'h19 ? 4'h9 : v[13:7] == 7'h63 ? 4'h6 : v[13:7] == 7'h62 ? 4'h7 :
      v[13:12] == 2'b11 ? 4'h3 : v[13:5] == 9'h001 ? 4'h5 : v[13:3] == 11'h002 ? 4'h8 : 4'h0;
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  initial begin
    sys_clk = 0; resetn = 0; branch_taken = 0; seed = 28694;
    n_mismatch = 0; checked = 0; cycles = 0;
    // The first six words walk the no-op and every two-cycle control code; the rest mix all classes.
    for (i = 0; i < 128; i = i + 1) begin
      r = $random(seed);
      t = (i < 6) ? i : r[5:3] % 6;
      case (i < 6 ? 6 : r[2:0])
        0, 1: begin
          w = {1'b0, r[0], r[12:1]};
          if (w[13:8] == 6'h00) w[7] = 1'b1;
          if (r[5]) w[6:1] = 6'h00;
        end
        2: w = {2'b10, r[11:0]};
        3: w = r[12] ? {6'h34, r[7:0]} : {5'h19, r[8:0]};
        4: w = r[12] ? {7'h63, r[6:0]} : r[11] ? {7'h62, r[6:0]} : {3'b111, r[10:0]};
        5: w = r[12] ? {9'h001, r[4:0]} : {11'h002, r[2:0]};
        default: w = (t == 0) ? 14'h0000 : (t == 5) ? 14'h000E : t + 7;
      endcase
      u_mem.mem[i] = w;
      u_mem.ind[i] = $random(seed);
    end
    repeat (10) @(negedge sys_clk);
    resetn = 1;
    for (k = 0; k < 64; k = k + 1) begin
      t = 0;
      while (fetch_ff !== 1'b1 && t < 20) begin
        @(negedge sys_clk);
        t = t + 1;
      end
      check(fetch_ff, 1'b1);
      if (k > 0) check(cycles - last, 4 * cyc_of(w, p, bt));
      last = cycles;
      w = u_mem.mem[k];
      p = u_mem.ind[k];
      bt = $random(seed);
      branch_taken = bt;
      @(negedge sys_clk);
      check(exec_ff, 1'b1);
      check(opcode_ff, w[13:8]);
      check(file_addr_ff, w[6:0]);
      check(dest_file_ff, w[7]);
      check(bit_sel_ff, w[9:7]);
      check(fmt_ff, fmt_of(w));
      check(rd_file_ff, file_of(w));
      if (fmt_of(w) == 4'h4) check(literal_ff, w[10:0]);
      if (fmt_of(w) == 4'h3) check(literal_ff, w[7:0]);
      if (fmt_of(w) == 4'h9) check(literal_ff, w[8:0]);
      if (fmt_of(w) == 4'h6) check(literal_ff, w[6:0]);
      if (fmt_of(w) == 4'h5) check(literal_ff, w[4:0]);
      if (fmt_of(w) == 4'h7) check(literal_ff, w[5:0]);
      check(ptr_sel_ff, fmt_of(w) == 4'h7 ? w[6] : fmt_of(w) == 4'h8 && w[2]);
      check(ptr_mode_ff, fmt_of(w) == 4'h8 ? w[1:0] : 2'h0);
      repeat (2) @(negedge sys_clk);
      check(wr_file_ff, file_of(w) && (w[12] ? !w[11] : w[7]));
      check(wr_acc_ff, file_of(w) && !w[12] && !w[7]);
      @(negedge sys_clk);
      check(idle_ff, cyc_of(w, p, bt) > 1);
    end
    conclude;
  end
endmodule
bind mid_decoder mid_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .fetch_ff(fetch_ff),
  .exec_ff(exec_ff), .opcode_ff(opcode_ff), .file_addr_ff(file_addr_ff),
  .dest_file_ff(dest_file_ff), .bit_sel_ff(bit_sel_ff), .rd_file_ff(rd_file_ff),
  .wr_file_ff(wr_file_ff), .idle_ff(idle_ff), .wr_acc_ff(wr_acc_ff));
